// File: hw/awd_top.sv
// Purpose: Watchdog timer, combined interrupt routing and general port enables of the auxiliary device.
// Assumes: Host index/data config cycles arrive as one-cycle strobes on ref_clk; keyboard, mouse and
//          keyboard controller lines are asynchronous pins; game port access and combined GPIO request
//          come from logic on ref_clk.
// Notes: Two resets; rst_b is main power-on or bus reset, stby_rst_b is standby power-on reset.
`timescale 1ns/1ps
`include "awd_defines.svh"

module awd_top
	import awd_pkg::*;
#(
	parameter int unsigned HALF_SEC_CYC = `AWD_HALF_SEC_CYC
) (
	// Clock and resets
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic stby_rst_b,
	// Host configuration access
	input wire logic cfg_mode,
	input wire logic cfg_sel,
	input wire logic dev_activate,
	input wire logic cfg_wr_stb,
	input wire logic cfg_rd_stb,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// Restart and force sources
	input wire logic game_port_access,
	input wire logic kbd_irq_pin,
	input wire logic mouse_irq_pin,
	input wire logic kbc_port_output_bit,
	// Combined GPIO requests
	input wire logic [1:0] gp_comb_req,
	// Outputs
	output logic [15:0] irq_out,
	output logic power_indicator,
	output logic general_port_address_decode,
	output logic general_port_write
);

	// ************************************************************
	// Functions
	// ************************************************************

	// One-hot IRQ line for a mapping nibble; disable and invalid give nothing
	function automatic awd_irq_t irq_map(input logic [3:0] sel, input logic req);
		awd_irq_t v;
		v = 16'h0000;
		if (req && sel != 4'h0 && sel != `AWD_MAP_INVALID) begin
			v[sel] = 1'b1;
		end
		return v;
	endfunction

	// Clean level from a pin synchroniser: change once stages two and three agree
	function automatic logic pin_clean(input logic s2, input logic s3, input logic cur);
		return (s2 == s3) ? s3 : cur;
	endfunction

	// ************************************************************
	// Reset release
	// ************************************************************
	logic [1:0] main_rst_sync_q;
	logic [1:0] stby_rst_sync_q;
	logic main_rst_n;
	logic stby_rst_n;

	// Both resets assert at once and release after two clean edges
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			main_rst_sync_q <= 2'h0;
		end else begin
			main_rst_sync_q <= {main_rst_sync_q[0], 1'b1};
		end
	end

	always_ff @(posedge ref_clk or negedge stby_rst_b) begin
		if (!stby_rst_b) begin
			stby_rst_sync_q <= 2'h0;
		end else begin
			stby_rst_sync_q <= {stby_rst_sync_q[0], 1'b1};
		end
	end

	assign main_rst_n = main_rst_sync_q[1];
	assign stby_rst_n = stby_rst_sync_q[1];

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Order of bits: 0 keyboard, 1 mouse, 2 controller port bit
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic [2:0] pin_s3_q;
	logic [2:0] pin_clean_q;
	logic [2:0] pin_clean_d;
	logic [2:0] pin_rise;

	// Three stages; only the second and third are compared
	always_ff @(posedge ref_clk or negedge main_rst_n) begin
		if (!main_rst_n) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
			pin_s3_q <= 3'h0;
			pin_clean_q <= 3'h0;
		end else begin
			pin_s1_q <= {kbc_port_output_bit, mouse_irq_pin, kbd_irq_pin};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_clean_q <= pin_clean_d;
		end
	end

	assign pin_clean_d[0] = pin_clean(pin_s2_q[0], pin_s3_q[0], pin_clean_q[0]);
	assign pin_clean_d[1] = pin_clean(pin_s2_q[1], pin_s3_q[1], pin_clean_q[1]);
	assign pin_clean_d[2] = pin_clean(pin_s2_q[2], pin_s3_q[2], pin_clean_q[2]);
	// Edge only; a line held high restarts or forces once
	assign pin_rise = pin_clean_d & ~pin_clean_q;

	// ************************************************************
	// Register decode
	// ************************************************************
	logic hit_comb_one;
	logic hit_comb_two;
	logic hit_gp_en;
	logic hit_wd_val;
	logic hit_wd_cfg;
	logic hit_wd_ctrl;
	logic wr_comb_one;
	logic wr_comb_two;
	logic wr_gp_en;
	logic wr_wd_val;
	logic wr_wd_cfg;
	logic wr_wd_ctrl;
	logic cfg_space;

	// Full index space only in config mode with this device selected
	assign cfg_space = cfg_mode && cfg_sel;
	assign hit_comb_one = cfg_space && cfg_index == `AWD_IDX_COMB_ONE;
	assign hit_comb_two = cfg_space && cfg_index == `AWD_IDX_COMB_TWO;
	assign hit_gp_en = cfg_space && cfg_index == `AWD_IDX_GP_EN;
	assign hit_wd_val = cfg_space && cfg_index == `AWD_IDX_WD_VAL;
	assign hit_wd_cfg = cfg_space && cfg_index == `AWD_IDX_WD_CFG;
	assign hit_wd_ctrl = (cfg_space && cfg_index == `AWD_IDX_WD_CTRL) ||
		(!cfg_mode && cfg_index == `AWD_IDX_WD_CTRL_LOW);
	assign wr_comb_one = cfg_wr_stb && hit_comb_one;
	assign wr_comb_two = cfg_wr_stb && hit_comb_two;
	assign wr_gp_en = cfg_wr_stb && hit_gp_en;
	assign wr_wd_val = cfg_wr_stb && hit_wd_val;
	assign wr_wd_cfg = cfg_wr_stb && hit_wd_cfg;
	assign wr_wd_ctrl = cfg_wr_stb && hit_wd_ctrl;

	// ************************************************************
	// Main-reset registers
	// ************************************************************
	awd_byte_t gp_en_q;
	awd_byte_t wd_val_q;
	awd_byte_t wd_cfg_q;

	// Cleared by main power-on or bus reset
	always_ff @(posedge ref_clk or negedge main_rst_n) begin
		if (!main_rst_n) begin
			gp_en_q <= `AWD_RST_BYTE;
			wd_val_q <= `AWD_RST_BYTE;
			wd_cfg_q <= `AWD_RST_BYTE;
		end else begin
			if (wr_gp_en) begin
				gp_en_q <= cfg_wdata & `AWD_GP_EN_MASK;
			end
			if (wr_wd_val) begin
				wd_val_q <= cfg_wdata;
			end
			if (wr_wd_cfg) begin
				wd_cfg_q <= cfg_wdata;
			end
		end
	end

	// ************************************************************
	// Standby-reset registers
	// ************************************************************
	awd_byte_t comb_one_q;
	awd_byte_t comb_two_q;
	logic stat_q;
	logic stat_d;
	logic led_en_q;
	logic p20_en_q;
	logic timeout_evt;

	// Status: a timeout in the clearing cycle still sets it
	assign stat_d = timeout_evt ? 1'b1 :
		(wr_wd_ctrl ? cfg_wdata[`AWD_CTRL_STAT_BIT] : stat_q);

	// Survive main reset; cleared only by standby power-on reset
	always_ff @(posedge ref_clk or negedge stby_rst_n) begin
		if (!stby_rst_n) begin
			comb_one_q <= `AWD_RST_BYTE;
			comb_two_q <= `AWD_RST_BYTE;
			stat_q <= 1'b0;
			led_en_q <= 1'b0;
			p20_en_q <= 1'b0;
		end else begin
			if (wr_comb_one) begin
				comb_one_q <= cfg_wdata & `AWD_COMB_MASK;
			end
			if (wr_comb_two) begin
				comb_two_q <= cfg_wdata & `AWD_COMB_MASK;
			end
			stat_q <= stat_d;
			if (wr_wd_ctrl) begin
				led_en_q <= cfg_wdata[`AWD_CTRL_LED_BIT];
				p20_en_q <= cfg_wdata[`AWD_CTRL_P20_BIT];
			end
		end
	end

	// ************************************************************
	// Timeout and restart sources
	// ************************************************************
	logic force_sw;
	logic force_kbc;
	logic restart_evt;
	logic reload;
	logic count_zero;
	logic unit_tick;

	// Software force needs no stored bit; the write itself is the pulse
	assign force_sw = wr_wd_ctrl && cfg_wdata[`AWD_CTRL_FORCE_BIT];
	assign force_kbc = p20_en_q && pin_rise[2];
	assign restart_evt = (wd_cfg_q[`AWD_CFG_GAME_BIT] && game_port_access) ||
		(wd_cfg_q[`AWD_CFG_KBD_BIT] && pin_rise[0]) ||
		(wd_cfg_q[`AWD_CFG_MOUSE_BIT] && pin_rise[1]);
	// Clearing status rearms the count as well
	assign reload = restart_evt || wr_wd_val ||
		(wr_wd_ctrl && !cfg_wdata[`AWD_CTRL_STAT_BIT] && stat_q);
	assign timeout_evt = force_sw || force_kbc || count_zero;

	// ************************************************************
	// Time base
	// ************************************************************
	logic [26:0] half_cnt_q;
	logic half_tick;
	logic half_ph_q;
	logic [5:0] sec_cnt_q;
	logic sec_tick;
	logic min_tick;
	logic blink_ph_q;
	awd_unit_t wd_unit_sel;

	assign half_tick = half_cnt_q == 27'(HALF_SEC_CYC - 1);
	assign sec_tick = half_tick && half_ph_q;
	assign min_tick = sec_tick && sec_cnt_q == 6'(`AWD_SEC_PER_MIN - 1);
	assign unit_tick = (wd_unit_sel == AWD_UNIT_SEC) ? sec_tick : min_tick;

	// Restarted on reload so a period is full units; blink phase runs free
	always_ff @(posedge ref_clk or negedge main_rst_n) begin
		if (!main_rst_n) begin
			half_cnt_q <= 27'h0000000;
			half_ph_q <= 1'b0;
			sec_cnt_q <= 6'h00;
			blink_ph_q <= 1'b0;
		end else begin
			if (half_tick) begin
				blink_ph_q <= ~blink_ph_q;
			end
			if (reload) begin
				half_cnt_q <= 27'h0000000;
				half_ph_q <= 1'b0;
				sec_cnt_q <= 6'h00;
			end else if (half_tick) begin
				half_cnt_q <= 27'h0000000;
				half_ph_q <= ~half_ph_q;
				if (sec_tick) begin
					sec_cnt_q <= min_tick ? 6'h00 : sec_cnt_q + 6'h01;
				end
			end else begin
				half_cnt_q <= half_cnt_q + 27'h0000001;
			end
		end
	end

	// ************************************************************
	// Watchdog counter
	// ************************************************************
	logic [7:0] wd_cnt_q;
	logic running;

	assign wd_unit_sel = awd_unit_t'(gp_en_q[`AWD_GP_UNIT_BIT]);
	// Counts only with a nonzero value and no pending status
	assign running = wd_val_q != 8'h00 && !stat_q && wd_cnt_q != 8'h00;
	assign count_zero = running && unit_tick && wd_cnt_q == 8'h01;

	// Load N, step once per unit, expire on the Nth step
	always_ff @(posedge ref_clk or negedge main_rst_n) begin
		if (!main_rst_n) begin
			wd_cnt_q <= 8'h00;
		end else if (reload) begin
			wd_cnt_q <= wr_wd_val ? cfg_wdata : wd_val_q;
		end else if (running && unit_tick) begin
			wd_cnt_q <= wd_cnt_q - 8'h01;
		end
	end

	// ************************************************************
	// Combined interrupt debounce
	// ************************************************************
	logic [1:0] comb_filt_q;
	logic [1:0] comb_seen_q;
	logic [3:0] deb_cnt_q [2];
	logic [1:0] comb_level;

	// Filter takes a new level once it held for the debounce time
	always_ff @(posedge ref_clk or negedge main_rst_n) begin
		if (!main_rst_n) begin
			comb_filt_q <= 2'h0;
			comb_seen_q <= 2'h0;
			deb_cnt_q[0] <= 4'h0;
			deb_cnt_q[1] <= 4'h0;
		end else begin
			comb_seen_q <= gp_comb_req;
			for (int i = 0; i < 2; i++) begin
				if (comb_seen_q[i] != gp_comb_req[i]) begin
					deb_cnt_q[i] <= 4'h0;
				end else if (deb_cnt_q[i] == 4'(`AWD_DEBOUNCE_CYC - 1)) begin
					comb_filt_q[i] <= comb_seen_q[i];
				end else begin
					deb_cnt_q[i] <= deb_cnt_q[i] + 4'h1;
				end
			end
		end
	end

	assign comb_level[0] = comb_one_q[`AWD_COMB_FILT_BIT] ? comb_filt_q[0] : gp_comb_req[0];
	assign comb_level[1] = comb_two_q[`AWD_COMB_FILT_BIT] ? comb_filt_q[1] : gp_comb_req[1];

	// ************************************************************
	// Read data and outputs
	// ************************************************************
	awd_byte_t rd_mux;
	awd_irq_t irq_d;
	logic blink;

	// Unmapped indices read zero; force bit always reads zero
	assign rd_mux = hit_comb_one ? comb_one_q :
		hit_comb_two ? comb_two_q :
		hit_gp_en ? gp_en_q :
		hit_wd_val ? wd_val_q :
		hit_wd_cfg ? wd_cfg_q :
		hit_wd_ctrl ? ({4'h0, p20_en_q, 1'b0, led_en_q, stat_q} & `AWD_CTRL_RD_MASK) :
		`AWD_RST_BYTE;

	assign irq_d = irq_map(wd_cfg_q[7:4], stat_q) |
		irq_map(comb_one_q[7:4], comb_level[0]) |
		irq_map(comb_two_q[7:4], comb_level[1]);

	assign blink = led_en_q || (wd_cfg_q[`AWD_CFG_LED_BIT] && stat_q);

	// Registered outputs; indicator steady on unless blinking
	always_ff @(posedge ref_clk or negedge main_rst_n) begin
		if (!main_rst_n) begin
			cfg_rdata <= `AWD_RST_BYTE;
			irq_out <= 16'h0000;
			power_indicator <= 1'b1;
			general_port_address_decode <= 1'b0;
			general_port_write <= 1'b0;
		end else begin
			if (cfg_rd_stb) begin
				cfg_rdata <= rd_mux;
			end
			irq_out <= irq_d;
			power_indicator <= blink ? blink_ph_q : 1'b1;
			general_port_address_decode <= dev_activate && gp_en_q[`AWD_GP_DEC_BIT];
			general_port_write <= dev_activate && gp_en_q[`AWD_GP_WR_BIT];
		end
	end

endmodule // awd_top

// File: common/awd_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the auxiliary watchdog block.
// Assumes: Core clock of 200 MHz.
// Notes: Definitions only, no logic.
`ifndef AWD_DEFINES_SVH
`define AWD_DEFINES_SVH

// ************************************************************
// Register indices
// ************************************************************
`define AWD_IDX_COMB_TWO 8'hEF
`define AWD_IDX_COMB_ONE 8'hF0
`define AWD_IDX_GP_EN 8'hF1
`define AWD_IDX_WD_VAL 8'hF2
`define AWD_IDX_WD_CFG 8'hF3
`define AWD_IDX_WD_CTRL 8'hF4
`define AWD_IDX_WD_CTRL_LOW 8'h03

// ************************************************************
// Field positions
// ************************************************************
`define AWD_COMB_FILT_BIT 3
`define AWD_GP_DEC_BIT 0
`define AWD_GP_WR_BIT 1
`define AWD_GP_UNIT_BIT 7
`define AWD_CFG_GAME_BIT 0
`define AWD_CFG_KBD_BIT 1
`define AWD_CFG_MOUSE_BIT 2
`define AWD_CFG_LED_BIT 3
`define AWD_CTRL_STAT_BIT 0
`define AWD_CTRL_LED_BIT 1
`define AWD_CTRL_FORCE_BIT 2
`define AWD_CTRL_P20_BIT 3

// ************************************************************
// Reset values and masks
// ************************************************************
`define AWD_RST_BYTE 8'h00
`define AWD_COMB_MASK 8'hF8
`define AWD_GP_EN_MASK 8'h83
`define AWD_CTRL_RD_MASK 8'h0B
`define AWD_MAP_INVALID 4'h2

// ************************************************************
// Timing
// ************************************************************
`define AWD_CLK_MHZ 200
`define AWD_HALF_SEC_MS 500
`define AWD_HALF_SEC_CYC (`AWD_HALF_SEC_MS * 1000 * `AWD_CLK_MHZ)
`define AWD_SEC_PER_MIN 60
`define AWD_DEBOUNCE_NS 80
`define AWD_DEBOUNCE_CYC ((`AWD_DEBOUNCE_NS * `AWD_CLK_MHZ + 999) / 1000)

`endif

// File: common/awd_pkg.sv
// Purpose: Shared types of the auxiliary watchdog block.
// Assumes: Used together with awd_defines.svh.
// Notes: Types only; numbers live in the defines header.
package awd_pkg;

	typedef logic [7:0] awd_byte_t;
	typedef logic [15:0] awd_irq_t;

	// Count unit of the watchdog
	typedef enum logic {
		AWD_UNIT_MIN = 1'b0,
		AWD_UNIT_SEC = 1'b1
	} awd_unit_t;

endpackage

// File: verif/awd_monitor.sv
// Purpose: Port-level checks of the auxiliary watchdog block.
// Assumes: Bound to awd_top; single clock domain.
// Notes: Mirrors the interrupt map and timeout value in helper logic.
`timescale 1ns/1ps

module awd_monitor
	import awd_pkg::*;
#(
	parameter int unsigned HALF_SEC_CYC = 20
) (
	// Clock and resets
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic stby_rst_b,
	// Host configuration access
	input wire logic cfg_mode,
	input wire logic cfg_sel,
	input wire logic dev_activate,
	input wire logic cfg_wr_stb,
	input wire logic cfg_rd_stb,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	// Outputs
	input wire logic [15:0] irq_out,
	input wire logic general_port_address_decode,
	input wire logic general_port_write
);
	// ****************************************
	// Helper mirrors
	// ****************************************
	logic [3:0] map_q;
	logic [7:0] val_q;
	logic hold_q;
	wire cfg_on = cfg_mode && cfg_sel;
	wire wr_f1 = cfg_wr_stb && cfg_on && cfg_index == 8'hF1;
	wire wr_f3 = cfg_wr_stb && cfg_on && cfg_index == 8'hF3;
	wire f4_hit = cfg_on && cfg_index == 8'hF4 || !cfg_mode && cfg_index == 8'h03;
	// Status clear or a new map may drop the line legally
	wire excl = cfg_wr_stb && f4_hit && !cfg_wdata[0] || wr_f3;

	// Mirrors follow main reset, like the registers they copy
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			map_q <= 4'h0;
			val_q <= 8'h00;
			hold_q <= 1'b0;
		end else begin
			map_q <= wr_f3 ? cfg_wdata[7:4] : map_q;
			val_q <= (cfg_wr_stb && cfg_on && cfg_index == 8'hF2) ? cfg_wdata : val_q;
			hold_q <= excl;
		end
	end

	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b || !stby_rst_b);

	a_gate_inactive: assert property (!dev_activate |=> !general_port_address_decode && !general_port_write)
		else $error("enable output high while device inactive");
	a_decode_follows: assert property (wr_f1 && dev_activate ##1 dev_activate |=>
		general_port_address_decode == $past(cfg_wdata[0], 2)) else $error("decode enable wrong");
	a_write_follows: assert property (wr_f1 && dev_activate ##1 dev_activate |=>
		general_port_write == $past(cfg_wdata[1], 2)) else $error("write enable wrong");
	a_reserved_comb_zero: assert property (cfg_rd_stb && cfg_on && cfg_index == 8'hF0 |=> cfg_rdata[2:0] == 3'h0)
		else $error("combined irq reserved bits not zero");
	a_reserved_enable_zero: assert property (cfg_rd_stb && cfg_on && cfg_index == 8'hF1 |=> cfg_rdata[6:2] == 5'h00)
		else $error("access enable reserved bits not zero");
	a_value_readback: assert property (cfg_rd_stb && cfg_on && cfg_index == 8'hF2 |=> cfg_rdata == $past(val_q))
		else $error("timeout value readback wrong");
	a_force_raises_irq: assert property (cfg_wr_stb && cfg_on && cfg_index == 8'hF4 && cfg_wdata[2] &&
		map_q != 4'h0 && map_q != 4'h2 |-> ##[1:4] irq_out[map_q]) else $error("forced timeout gave no irq");
	a_bad_map_silent: assert property (irq_out[0] == 1'b0 && irq_out[2] == 1'b0)
		else $error("disabled or invalid map drove a line");
	a_irq_held: assert property (irq_out[map_q] && !excl && !hold_q |=> irq_out[map_q])
		else $error("watchdog irq dropped without clear");

endmodule // awd_monitor

bind awd_top awd_monitor #(.HALF_SEC_CYC(HALF_SEC_CYC)) u_awd_monitor (
	.ref_clk(ref_clk), .rst_b(rst_b), .stby_rst_b(stby_rst_b), .cfg_mode(cfg_mode), .cfg_sel(cfg_sel),
	.dev_activate(dev_activate), .cfg_wr_stb(cfg_wr_stb), .cfg_rd_stb(cfg_rd_stb), .cfg_index(cfg_index),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .irq_out(irq_out),
	.general_port_address_decode(general_port_address_decode), .general_port_write(general_port_write));

// File: verif/awd_host_model.sv
// Purpose: Host side of the configuration access.
// Assumes: One-cycle strobes on ref_clk, read data one cycle later.
// Notes: Data is inverted on release so a stale value never looks valid.
`timescale 1ns/1ps

module awd_host_model
	import awd_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Config bus
	output logic cfg_mode,
	output logic cfg_sel,
	output logic cfg_wr_stb,
	output logic cfg_rd_stb,
	output logic [7:0] cfg_index,
	output logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata
);
	// Idle bus at time zero
	initial begin
		cfg_mode = 1'b1;
		cfg_sel = 1'b1;
		cfg_wr_stb = 1'b0;
		cfg_rd_stb = 1'b0;
		cfg_index = 8'h00;
		cfg_wdata = 8'h00;
	end

	// One access; mode and index stay put after the strobe
	task automatic xfer(input logic wr, input logic mode, input awd_byte_t idx, input awd_byte_t wd,
		output awd_byte_t rd);
		@(posedge ref_clk);
		cfg_mode <= mode;
		cfg_sel <= mode;
		cfg_index <= idx;
		cfg_wdata <= wd;
		cfg_wr_stb <= wr;
		cfg_rd_stb <= !wr;
		@(posedge ref_clk);
		cfg_wr_stb <= 1'b0;
		cfg_rd_stb <= 1'b0;
		cfg_wdata <= ~wd;
		@(posedge ref_clk);
		rd = cfg_rdata;
	endtask

endmodule // awd_host_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the auxiliary watchdog block.
// Assumes: Half second shortened to 20 cycles, so a second is 40 and a minute 2400.
// Notes: Watchdog interrupt is mapped to line 3 until the main reset test clears the map.
`timescale 1ns/1ps

module tb_top
	import awd_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic stby_rst_b = 1'b0;
	logic dev_activate = 1'b1;
	logic game_port_access = 1'b0;
	logic kbd_irq_pin = 1'b0;
	logic mouse_irq_pin = 1'b0;
	logic kbc_port_output_bit = 1'b0;
	logic [1:0] gp_comb_req = 2'h0;
	logic cfg_mode, cfg_sel, cfg_wr_stb, cfg_rd_stb;
	logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
	logic [15:0] irq_out;
	logic power_indicator, general_port_address_decode, general_port_write;
	int fails = 0;
	int checks = 0;
	awd_byte_t rd;
	awd_byte_t idx_t [6] = '{8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4};
	awd_byte_t wd_t [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hA5, 8'h35, 8'h0A};
	awd_byte_t ex_t [6] = '{8'hF8, 8'hF8, 8'h83, 8'hA5, 8'h35, 8'h0A};
	awd_byte_t cfg_t [6] = '{8'h31, 8'h32, 8'h34, 8'h30, 8'h30, 8'h30};
	awd_byte_t map_t [5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'hF0};
	awd_irq_t irq_t [5] = '{16'h0000, 16'h0002, 16'h0000, 16'h0008, 16'h8000};

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	awd_top #(.HALF_SEC_CYC(20)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .stby_rst_b(stby_rst_b),
		.cfg_mode(cfg_mode), .cfg_sel(cfg_sel), .dev_activate(dev_activate), .cfg_wr_stb(cfg_wr_stb),
		.cfg_rd_stb(cfg_rd_stb), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.game_port_access(game_port_access), .kbd_irq_pin(kbd_irq_pin), .mouse_irq_pin(mouse_irq_pin),
		.kbc_port_output_bit(kbc_port_output_bit), .gp_comb_req(gp_comb_req), .irq_out(irq_out),
		.power_indicator(power_indicator), .general_port_address_decode(general_port_address_decode),
		.general_port_write(general_port_write));
	awd_host_model host (.ref_clk(ref_clk), .cfg_mode(cfg_mode), .cfg_sel(cfg_sel), .cfg_wr_stb(cfg_wr_stb),
		.cfg_rd_stb(cfg_rd_stb), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input awd_byte_t idx, input awd_byte_t wd);
		host.xfer(1'b1, 1'b1, idx, wd, rd);
	endtask
	task automatic rdc(input logic mode, input awd_byte_t idx, input awd_byte_t exp);
		host.xfer(1'b0, mode, idx, 8'h00, rd);
		chk({8'h00, rd}, {8'h00, exp});
	endtask
	// Lands one ns past the edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Game port is a one-cycle strobe; pins are held long enough to sync
	task automatic pulse(input int src);
		@(posedge ref_clk);
		game_port_access <= (src == 0);
		kbd_irq_pin <= (src == 1);
		mouse_irq_pin <= (src == 2);
		@(posedge ref_clk);
		game_port_access <= 1'b0;
		repeat (3) @(posedge ref_clk);
		kbd_irq_pin <= 1'b0;
		mouse_irq_pin <= 1'b0;
	endtask
	task automatic blinks(input int exp);
		int n = 0;
		logic prev;
		// Step off the write's edge so the indicator has settled
		cyc(1);
		prev = power_indicator;
		repeat (200) begin
			cyc(1);
			n += (power_indicator !== prev);
			prev = power_indicator;
		end
		chk(n[15:0], exp[15:0]);
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, well above the few thousand cycles expected
	initial begin
		cyc(20000);
		fails++;
		$display("ERROR %0t: run did not finish", $time);
		final_report();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		stby_rst_b <= 1'b1;
		cyc(4);
		foreach (idx_t[i]) rdc(1'b1, idx_t[i], 8'h00);
		foreach (idx_t[i]) begin
			wr(idx_t[i], wd_t[i]);
			rdc(1'b1, idx_t[i], ex_t[i]);
		end
		rdc(1'b0, 8'h03, 8'h0A);
		rdc(1'b1, 8'hF5, 8'h00);
		cyc(2);
		chk({general_port_write, general_port_address_decode}, 2'b11);
		@(posedge ref_clk) dev_activate <= 1'b0;
		cyc(3);
		chk({general_port_write, general_port_address_decode}, 2'b00);
		@(posedge ref_clk) dev_activate <= 1'b1;
		foreach (idx_t[i]) wr(idx_t[i], 8'h00);
		// Restart sources, enabled then disabled, two-second timeout
		wr(8'hF1, 8'h80);
		for (int s = 0; s < 6; s++) begin
			wr(8'hF3, cfg_t[s]);
			wr(8'hF2, 8'h02);
			cyc(60);
			pulse(s % 3);
			cyc(62);
			chk(irq_out, (s < 3) ? 16'h0000 : 16'h0008);
			cyc(28);
			chk(irq_out, 16'h0008);
			wr(8'hF4, 8'h00);
		end
		wr(8'hF2, 8'h00);
		cyc(200);
		chk(irq_out, 16'h0000);
		wr(8'hF1, 8'h00);
		wr(8'hF2, 8'h01);
		cyc(2380);
		chk(irq_out, 16'h0000);
		cyc(40);
		chk(irq_out, 16'h0008);
		wr(8'hF2, 8'h00);
		wr(8'hF4, 8'h00);
		// Software and controller-edge forced timeouts
		wr(8'hF4, 8'h04);
		rdc(1'b1, 8'hF4, 8'h01);
		chk(irq_out, 16'h0008);
		wr(8'hF4, 8'h00);
		cyc(3);
		chk(irq_out, 16'h0000);
		wr(8'hF4, 8'h08);
		@(posedge ref_clk) kbc_port_output_bit <= 1'b1;
		cyc(10);
		chk(irq_out, 16'h0008);
		wr(8'hF4, 8'h08);
		cyc(20);
		chk(irq_out, 16'h0000);
		wr(8'hF4, 8'h00);
		@(posedge ref_clk) kbc_port_output_bit <= 1'b0;
		cyc(6);
		@(posedge ref_clk) kbc_port_output_bit <= 1'b1;
		cyc(10);
		chk(irq_out, 16'h0000);
		// Indicator blinking, by control bit and by timeout status
		wr(8'hF4, 8'h02);
		blinks(10);
		wr(8'hF4, 8'h00);
		cyc(3);
		chk(power_indicator, 1'b1);
		wr(8'hF3, 8'h38);
		wr(8'hF4, 8'h04);
		blinks(10);
		wr(8'hF3, 8'h30);
		cyc(3);
		blinks(0);
		// Main reset spares control and combined map; standby reset clears them
		wr(8'hF0, 8'h18);
		@(posedge ref_clk) rst_b <= 1'b0;
		cyc(2);
		@(posedge ref_clk) rst_b <= 1'b1;
		cyc(4);
		rdc(1'b1, 8'hF3, 8'h00);
		rdc(1'b1, 8'hF4, 8'h01);
		rdc(1'b1, 8'hF0, 8'h18);
		@(posedge ref_clk) stby_rst_b <= 1'b0;
		cyc(2);
		@(posedge ref_clk) stby_rst_b <= 1'b1;
		cyc(4);
		rdc(1'b1, 8'hF4, 8'h00);
		rdc(1'b1, 8'hF0, 8'h00);
		// Combined interrupt routing, every listed code on both registers
		@(posedge ref_clk) gp_comb_req <= 2'b11;
		for (int j = 0; j < 2; j++) begin
			foreach (map_t[i]) begin
				wr(j ? 8'hEF : 8'hF0, map_t[i]);
				cyc(3);
				chk(irq_out, irq_t[i]);
			end
			wr(j ? 8'hEF : 8'hF0, 8'h00);
		end
		// Filter swallows a short request and passes a long one
		@(posedge ref_clk) gp_comb_req <= 2'b00;
		// Let the filter drop the high level left by the routing test
		cyc(20);
		wr(8'hF0, 8'hF8);
		@(posedge ref_clk) gp_comb_req <= 2'b01;
		cyc(3);
		@(posedge ref_clk) gp_comb_req <= 2'b00;
		cyc(4);
		chk(irq_out, 16'h0000);
		@(posedge ref_clk) gp_comb_req <= 2'b01;
		cyc(30);
		chk(irq_out, 16'h8000);
		final_report();
	end

endmodule // tb_top
